// ---- csr_core.v ----
// holds the charge stage regulator with apb registers and presets
// assumes vbat sample and night come from other clock domains; tick is a pclk pulse
`timescale 1ns/10ps
`default_nettype none
`include "csr_regs.vh"
// How it works
// - programs 0-3 enable low battery disconnect
// - programs 2,3 light load all night
// - presets fixed; only program 4 editable
// - setpoints multiplied by system voltage ratio
// - preset boost, absorption, gap, current cap
// - boost, equalise, absorption volts clamped
// - equalise interval clamped 20-150 days
// - switching gap clamped 0.1-1.0 v
// - return to boost below return threshold
// - forced boost after max days
// - temperature profile limited to 0-8
// - cut at setpoint, resume below gap
// - float uses same on/off band
// - absorption timer halts below setpoint minus gap
// - boost and equalise timers gated alike
// - advance after full stage duration; equalise also at the cutoff
// - equalise ends after four days
// - switch polarity 0 means on while charging
// - over cap reduces charge duty
// - lockout refuses all setting changes except the lock bit itself
module csr_core #(
  parameter TENTH_HOUR_TICKS = 16'd3600
) (
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // measurement
  input wire tick,
  input wire [11:0] vbat_raw,
  input wire [7:0] ichg_raw,
  input wire night_raw,
  // switches
  output reg charge_sw_ff,
  output reg load_sw_ff,
  output reg [1:0] stage_ff
);
  localparam S_BOOST = 4'b0001;
  localparam S_EQU = 4'b0010;
  localparam S_ABS = 4'b0100;
  localparam S_FLT = 4'b1000;

  // ****************************************
  // input synchronisers
  // ****************************************
  reg [11:0] vb_s1_ff, vb_s2_ff, vb_s3_ff, vb_ff;
  reg [7:0] ic_s1_ff, ic_s2_ff, ic_s3_ff, ic_ff;
  reg nt_s1_ff, nt_s2_ff;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vb_s1_ff <= 12'h000;
      vb_s2_ff <= 12'h000;
      vb_s3_ff <= 12'h000;
      vb_ff <= 12'h000;
      ic_s1_ff <= 8'h00;
      ic_s2_ff <= 8'h00;
      ic_s3_ff <= 8'h00;
      ic_ff <= 8'h00;
      nt_s1_ff <= 1'b0;
      nt_s2_ff <= 1'b0;
    end else begin
      vb_s1_ff <= vbat_raw;
      vb_s2_ff <= vb_s1_ff;
      vb_s3_ff <= vb_s2_ff;
      // words taken only when two samples agree; a bus caught mid-change never leaks through
      if (vb_s3_ff == vb_s2_ff) begin
        vb_ff <= vb_s2_ff;
      end
      ic_s1_ff <= ichg_raw;
      ic_s2_ff <= ic_s1_ff;
      ic_s3_ff <= ic_s2_ff;
      if (ic_s3_ff == ic_s2_ff) begin
        ic_ff <= ic_s2_ff;
      end
      nt_s1_ff <= night_raw;
      nt_s2_ff <= nt_s1_ff;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  reg [31:0] ctrl_ff;
  reg [8:0] boost_ceiling_volts_ff, equalise_volts_ff, absorption_volts_ff, float_volts_ff;
  reg [8:0] switching_gap_volts_ff, boost_return_threshold_ff;
  reg [5:0] equalise_duration_ff, absorption_duration_ff, charge_current_cap_ff;
  reg [7:0] equalise_interval_days_ff;
  reg [4:0] max_days_between_boosts_ff;
  reg [3:0] temperature_profile_select_ff;
  wire [2:0] preset_select = ctrl_ff[`CSR_CTRL_PRESET_SELECT_MSB:`CSR_CTRL_PRESET_SELECT_LSB];
  wire lockout = ctrl_ff[`CSR_CTRL_LOCK_BIT];
  wire charge_switch_polarity = ctrl_ff[`CSR_CTRL_POL_BIT];
  wire pwm_mode = ctrl_ff[`CSR_CTRL_PWM_BIT];
  wire [3:0] volt_mult = ctrl_ff[`CSR_CTRL_MULT_MSB:`CSR_CTRL_MULT_LSB];
  wire custom = (preset_select == 3'd4);
  wire sealed = preset_select[0];

  wire wr = psel & penable & pwrite;
  wire [8:0] cl_boost, cl_equ, cl_abs, cl_flt, cl_gap, cl_rtn;
  wire [7:0] cl_eqf;
  wire [4:0] cl_bf;
  wire [5:0] cl_cap, cl_eqt, cl_abt;
  wire [3:0] cl_tc;
  wire [8:0] wlo = pwdata[8:0];
  wire [8:0] whi = pwdata[24:16];
  csr_clamp #(.W(9)) u_c0 (.lo(`CSR_BOOST_MIN), .hi(`CSR_BOOST_MAX), .din(wlo), .dout(cl_boost));
  csr_clamp #(.W(9)) u_c1 (.lo(`CSR_EQU_MIN), .hi(`CSR_EQU_MAX), .din(whi), .dout(cl_equ));
  csr_clamp #(.W(9)) u_c2 (.lo(`CSR_ABS_MIN), .hi(`CSR_ABS_MAX), .din(wlo), .dout(cl_abs));
  csr_clamp #(.W(9)) u_c3 (.lo(`CSR_FLT_MIN), .hi(`CSR_FLT_MAX), .din(wlo), .dout(cl_flt));
  csr_clamp #(.W(9)) u_c4 (.lo(`CSR_GAP_MIN), .hi(`CSR_GAP_MAX), .din(wlo), .dout(cl_gap));
  csr_clamp #(.W(9)) u_c5 (.lo(`CSR_RTN_MIN), .hi(`CSR_RTN_MAX), .din(whi), .dout(cl_rtn));
  csr_clamp #(.W(8)) u_c6 (.lo(`CSR_EQFRQ_MIN), .hi(`CSR_EQFRQ_MAX), .din(pwdata[7:0]),
    .dout(cl_eqf));
  csr_clamp #(.W(5)) u_c7 (.lo(`CSR_MAX_DAYS_BETWEEN_BOOSTS_MIN), .hi(`CSR_MAX_DAYS_BETWEEN_BOOSTS_MAX), .din(pwdata[12:8]),
    .dout(cl_bf));
  csr_clamp #(.W(6)) u_c8 (.lo(`CSR_CAP_MIN), .hi(`CSR_CAP_MAX), .din(pwdata[21:16]),
    .dout(cl_cap));
  csr_clamp #(.W(4)) u_c9 (.lo(4'h0), .hi(`CSR_TEMPERATURE_PROFILE_SELECT_MAX), .din(pwdata[27:24]), .dout(cl_tc));
  // equalise duration sits above the volts field so the two never share a bit
  csr_clamp #(.W(6)) u_ca (.lo(6'h00), .hi(`CSR_EQT_MAX), .din(pwdata[31:26]), .dout(cl_eqt));
  csr_clamp #(.W(6)) u_cb (.lo(6'h00), .hi(`CSR_ABST_MAX), .din(pwdata[29:24]), .dout(cl_abt));

  wire adj_ok = custom & ~lockout;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `CSR_CTRL_RST;
      boost_ceiling_volts_ff <= `CSR_P_BOOST_FLD;
      equalise_volts_ff <= `CSR_P_EQU_FLD;
      absorption_volts_ff <= `CSR_P_ABS;
      float_volts_ff <= `CSR_P_FLT;
      switching_gap_volts_ff <= `CSR_P_GAP;
      boost_return_threshold_ff <= `CSR_P_RTN;
      equalise_duration_ff <= `CSR_P_EQT_FLD;
      absorption_duration_ff <= `CSR_P_ABST;
      charge_current_cap_ff <= `CSR_P_CAP;
      equalise_interval_days_ff <= `CSR_P_EQFRQ;
      max_days_between_boosts_ff <= `CSR_P_MAX_DAYS_BETWEEN_BOOSTS;
      temperature_profile_select_ff <= `CSR_P_TEMPERATURE_PROFILE_SELECT;
    end else if (wr) begin
      if (paddr == `CSR_CTRL_OFF) begin
        // lock bit itself stays writable so software can unlock
        if (!lockout && pwdata[2:0] <= 3'd4) begin
          ctrl_ff[2:0] <= pwdata[2:0];
        end
        if (!lockout) begin
          ctrl_ff[`CSR_CTRL_POL_BIT] <= pwdata[`CSR_CTRL_POL_BIT];
          ctrl_ff[`CSR_CTRL_PWM_BIT] <= pwdata[`CSR_CTRL_PWM_BIT];
          ctrl_ff[11:8] <= (pwdata[11:8] == 4'h0) ? 4'h1 : pwdata[11:8];
        end
        ctrl_ff[`CSR_CTRL_LOCK_BIT] <= pwdata[`CSR_CTRL_LOCK_BIT];
      end
      if (adj_ok) begin
        case (paddr)
          `CSR_BOOST_OFF: boost_ceiling_volts_ff <= cl_boost;
          `CSR_EQU_OFF: begin
            equalise_volts_ff <= cl_equ;
            equalise_interval_days_ff <= cl_eqf;
            equalise_duration_ff <= cl_eqt;
          end
          `CSR_ABS_OFF: begin
            absorption_volts_ff <= cl_abs;
            absorption_duration_ff <= cl_abt;
          end
          `CSR_FLT_OFF: float_volts_ff <= cl_flt;
          `CSR_GAP_OFF: begin
            switching_gap_volts_ff <= cl_gap;
            boost_return_threshold_ff <= cl_rtn;
          end
          `CSR_MISC_OFF: begin
            max_days_between_boosts_ff <= cl_bf;
            charge_current_cap_ff <= cl_cap;
            temperature_profile_select_ff <= cl_tc;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ****************************************
  // active setpoints
  // ****************************************
  reg [8:0] a_boost, a_equ, a_abs, a_flt, a_gap, a_rtn;
  reg [5:0] a_eqt, a_abt, a_cap;
  reg [4:0] a_bf;
  always @* begin
    if (custom) begin
      a_boost = boost_ceiling_volts_ff;
      a_equ = equalise_volts_ff;
      a_abs = absorption_volts_ff;
      a_flt = float_volts_ff;
      a_gap = switching_gap_volts_ff;
      a_rtn = boost_return_threshold_ff;
      a_eqt = equalise_duration_ff;
      a_abt = absorption_duration_ff;
      a_cap = charge_current_cap_ff;
      a_bf = max_days_between_boosts_ff;
    end else begin
      a_boost = sealed ? `CSR_P_BOOST_SLD : `CSR_P_BOOST_FLD;
      a_equ = sealed ? `CSR_P_EQU_SLD : `CSR_P_EQU_FLD;
      a_abs = `CSR_P_ABS;
      a_flt = `CSR_P_FLT;
      a_gap = `CSR_P_GAP;
      a_rtn = `CSR_P_RTN;
      a_eqt = sealed ? `CSR_P_EQT_SLD : `CSR_P_EQT_FLD;
      a_abt = `CSR_P_ABST;
      a_cap = `CSR_P_CAP;
      a_bf = `CSR_P_MAX_DAYS_BETWEEN_BOOSTS;
    end
  end

  // scale to system voltage
  wire [12:0] mult_w = {9'h000, volt_mult};
  wire [12:0] sc_boost = {4'h0, a_boost} * mult_w;
  wire [12:0] sc_equ = {4'h0, a_equ} * mult_w;
  wire [12:0] sc_abs = {4'h0, a_abs} * mult_w;
  wire [12:0] sc_flt = {4'h0, a_flt} * mult_w;
  wire [12:0] sc_gap = {4'h0, a_gap} * mult_w;
  wire [12:0] sc_rtn = {4'h0, a_rtn} * mult_w;
  wire [12:0] vb = {1'b0, vb_ff};

  reg [12:0] set_v;
  always @* begin
    case (stage_ff)
      2'd0: set_v = sc_boost;
      2'd1: set_v = sc_equ;
      2'd2: set_v = sc_abs;
      default: set_v = sc_flt;
    endcase
  end
  wire [12:0] low_v = (set_v > sc_gap) ? set_v - sc_gap : 13'h0000;

  // ****************************************
  // tenth hour base and stage machine
  // ****************************************
  reg [15:0] tick_cnt_ff;
  reg tenth_ff;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_ff <= 16'h0000;
      tenth_ff <= 1'b0;
    end else begin
      tenth_ff <= 1'b0;
      if (tick) begin
        if (tick_cnt_ff >= TENTH_HOUR_TICKS - 16'd1) begin
          tick_cnt_ff <= 16'h0000;
          tenth_ff <= 1'b1;
        end else begin
          tick_cnt_ff <= tick_cnt_ff + 16'd1;
        end
      end
    end
  end

  reg [3:0] st_ff;
  reg [9:0] stg_tmr_ff, eq_wall_ff;
  reg [7:0] day_tenth_ff, days_eq_ff;
  reg [4:0] days_boost_ff;
  reg tenth_pend_ff, charging_ff;
  reg [7:0] duty_ff;
  wire above = vb > low_v;
  wire boost_due = ({3'b000, days_boost_ff} >= {3'b000, a_bf}) | (vb < sc_rtn);
  wire eq_due = custom ? (days_eq_ff >= equalise_interval_days_ff) : (days_eq_ff >= `CSR_P_EQFRQ);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= S_BOOST;
      stage_ff <= 2'd0;
      stg_tmr_ff <= 10'h000;
      eq_wall_ff <= 10'h000;
      day_tenth_ff <= 8'h00;
      days_eq_ff <= 8'h00;
      days_boost_ff <= 5'h00;
      tenth_pend_ff <= 1'b0;
      // switch stays off until the first tick has judged the battery
      charging_ff <= 1'b0;
      duty_ff <= 8'h00;
      charge_sw_ff <= 1'b0;
      load_sw_ff <= 1'b0;
    end else begin
      if (tenth_ff) begin
        tenth_pend_ff <= 1'b1;
      end
      if (tick) begin
        tenth_pend_ff <= tenth_ff;
        if (tenth_pend_ff) begin
          if (day_tenth_ff == `CSR_TENTHS_PER_DAY - 8'd1) begin
            day_tenth_ff <= 8'h00;
            if (days_eq_ff != 8'hff) days_eq_ff <= days_eq_ff + 8'd1;
            if (days_boost_ff != 5'h1f) days_boost_ff <= days_boost_ff + 5'd1;
          end else begin
            day_tenth_ff <= day_tenth_ff + 8'd1;
          end
          if (above && stg_tmr_ff != 10'h3ff) stg_tmr_ff <= stg_tmr_ff + 10'd1;
          if (st_ff == S_EQU) eq_wall_ff <= eq_wall_ff + 10'd1;
        end
        // on/off band control
        if (vb >= set_v) begin
          charging_ff <= 1'b0;
        end else if (vb <= low_v) begin
          charging_ff <= 1'b1;
        end
        // current cap trims duty; pwm average falls to the cap
        if (ic_ff > {2'b00, a_cap}) begin
          if (duty_ff != 8'h00) duty_ff <= duty_ff - 8'd1;
        end else if (duty_ff != 8'hff) begin
          duty_ff <= duty_ff + 8'd1;
        end
        case (st_ff)
          S_BOOST: begin
            if (stg_tmr_ff >= {4'h0, a_abt}) begin
              st_ff <= eq_due ? S_EQU : S_ABS;
              stage_ff <= eq_due ? 2'd1 : 2'd2;
              stg_tmr_ff <= 10'h000;
              eq_wall_ff <= 10'h000;
              days_boost_ff <= 5'h00;
            end
          end
          S_EQU: begin
            if (stg_tmr_ff >= {4'h0, a_eqt} || eq_wall_ff >= `CSR_EQU_CUTOFF) begin
              st_ff <= S_ABS;
              stage_ff <= 2'd2;
              stg_tmr_ff <= 10'h000;
              days_eq_ff <= 8'h00;
            end
          end
          S_ABS: begin
            if (vb < sc_rtn) begin
              st_ff <= S_BOOST;
              stage_ff <= 2'd0;
              stg_tmr_ff <= 10'h000;
            end else if (stg_tmr_ff >= {4'h0, a_abt}) begin
              st_ff <= S_FLT;
              stage_ff <= 2'd3;
              stg_tmr_ff <= 10'h000;
            end
          end
          S_FLT: begin
            if (boost_due) begin
              st_ff <= S_BOOST;
              stage_ff <= 2'd0;
              stg_tmr_ff <= 10'h000;
            end
          end
          default: begin
            st_ff <= S_BOOST;
            stage_ff <= 2'd0;
          end
        endcase
      end
      // pwm mode: duty compared with a free phase; on/off otherwise
      charge_sw_ff <= (pwm_mode ? (tick_cnt_ff[7:0] < duty_ff) : charging_ff) ^ charge_switch_polarity;
      // presets disconnect low battery; 2,3 add night light
      if (!custom) begin
        load_sw_ff <= (vb > sc_rtn - sc_gap) & (preset_select[1] ? nt_s2_ff : 1'b1);
      end else begin
        load_sw_ff <= 1'b1;
      end
    end
  end

  // ****************************************
  // apb read side
  // ****************************************
  reg [31:0] rd;
  always @* begin
    rd = 32'h0000_0000;
    case (paddr)
      `CSR_CTRL_OFF: rd = {20'h00000, ctrl_ff[11:0]};
      `CSR_BOOST_OFF: rd = {23'h000000, a_boost};
      `CSR_EQU_OFF: rd = {a_eqt, 1'b0, a_equ, 8'h00, custom ? equalise_interval_days_ff : `CSR_P_EQFRQ};
      `CSR_ABS_OFF: rd = {2'b00, a_abt, 15'h0000, a_abs};
      `CSR_FLT_OFF: rd = {23'h000000, a_flt};
      `CSR_GAP_OFF: rd = {7'h00, a_rtn, 7'h00, a_gap};
      `CSR_MISC_OFF: rd = {4'h0, custom ? temperature_profile_select_ff : `CSR_P_TEMPERATURE_PROFILE_SELECT, 2'b00, a_cap,
        3'b000, a_bf, 8'h00};
      `CSR_STAT_OFF: rd = {22'h000000, load_sw_ff, charge_sw_ff, duty_ff};
      `CSR_VBAT_OFF: rd = {20'h00000, vb_ff};
      `CSR_TMR_OFF: rd = {6'h00, days_eq_ff, days_boost_ff[3:0], 4'h0, stg_tmr_ff};
      default: rd = 32'h0000_0000;
    endcase
  end
  wire mapped = (paddr[1:0] == 2'b00) && (paddr <= `CSR_TMR_OFF);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel & ~penable & ~pwrite) prdata <= rd;
    end
  end
endmodule
`default_nettype wire

// ---- csr_regs.vh ----
// holds register offsets, field layouts, reset values and timing counts
// assumes voltages in units of 0.1 v at 12 v scaling, durations in units of 0.1 h
`ifndef CSR_REGS_VH
`define CSR_REGS_VH
// register byte offsets
`define CSR_CTRL_OFF 12'h000
`define CSR_BOOST_OFF 12'h004
`define CSR_EQU_OFF 12'h008
`define CSR_ABS_OFF 12'h00c
`define CSR_FLT_OFF 12'h010
`define CSR_GAP_OFF 12'h014
`define CSR_MISC_OFF 12'h018
`define CSR_STAT_OFF 12'h01c
`define CSR_VBAT_OFF 12'h020
`define CSR_TMR_OFF 12'h024
// ctrl fields
`define CSR_CTRL_PRESET_SELECT_LSB 0
`define CSR_CTRL_PRESET_SELECT_MSB 2
`define CSR_CTRL_LOCK_BIT 3
`define CSR_CTRL_POL_BIT 4
`define CSR_CTRL_PWM_BIT 5
`define CSR_CTRL_MULT_LSB 8
`define CSR_CTRL_MULT_MSB 11
`define CSR_CTRL_RST 32'h0000_0100
// preset setpoints, 0.1 v and 0.1 h
`define CSR_P_BOOST_FLD 9'h096
`define CSR_P_BOOST_SLD 9'h08e
`define CSR_P_EQU_FLD 9'h0a0
`define CSR_P_EQU_SLD 9'h08c
`define CSR_P_EQT_FLD 6'h0a
`define CSR_P_EQT_SLD 6'h00
`define CSR_P_EQFRQ 8'h2d
`define CSR_P_ABS 9'h08c
`define CSR_P_ABST 6'h14
`define CSR_P_FLT 9'h08a
`define CSR_P_GAP 9'h004
`define CSR_P_RTN 9'h07b
`define CSR_P_CAP 6'h28
`define CSR_P_MAX_DAYS_BETWEEN_BOOSTS 5'h0f
`define CSR_P_TEMPERATURE_PROFILE_SELECT 4'h0
// adjustable ranges
`define CSR_BOOST_MIN 9'h087
`define CSR_BOOST_MAX 9'h0a5
`define CSR_EQU_MIN 9'h08c
`define CSR_EQU_MAX 9'h0aa
`define CSR_ABS_MIN 9'h087
`define CSR_ABS_MAX 9'h09b
`define CSR_FLT_MIN 9'h082
`define CSR_FLT_MAX 9'h096
`define CSR_GAP_MIN 9'h001
`define CSR_GAP_MAX 9'h00a
`define CSR_RTN_MIN 9'h06e
`define CSR_RTN_MAX 9'h082
`define CSR_EQT_MAX 6'h14
`define CSR_ABST_MAX 6'h28
`define CSR_EQFRQ_MIN 8'h14
`define CSR_EQFRQ_MAX 8'h96
`define CSR_MAX_DAYS_BETWEEN_BOOSTS_MIN 5'h01
`define CSR_MAX_DAYS_BETWEEN_BOOSTS_MAX 5'h14
`define CSR_CAP_MIN 6'h01
`define CSR_CAP_MAX 6'h28
`define CSR_TEMPERATURE_PROFILE_SELECT_MAX 4'h8
// equalise cutoff in tenths of an hour: 4 days
`define CSR_EQU_CUTOFF 10'h3c0
// tenths of an hour per day
`define CSR_TENTHS_PER_DAY 8'hf0
`endif

// ---- csr_clamp.v ----
// holds a saturating range limiter for one setting
// assumes lo is not above hi
`timescale 1ns/10ps
`default_nettype none
module csr_clamp #(
  parameter W = 9
) (
  // range
  input wire [W-1:0] lo,
  input wire [W-1:0] hi,
  // value
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  always @* begin
    if (din < lo) begin
      dout = lo;
    end else if (din > hi) begin
      dout = hi;
    end else begin
      dout = din;
    end
  end
endmodule
`default_nettype wire

// ---- csr_core_assertions.sv ----
// checker for the regulator block: apb answer timing, error response, output pacing
// assumes one pclk domain with async active low presetn; bound to csr_core
`timescale 1ns/10ps
`default_nettype none
module csr_core_chk #(
  parameter TENTH_HOUR_TICKS = 16'd3600
) (
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // measurement
  input wire tick,
  input wire [11:0] vbat_raw,
  input wire [7:0] ichg_raw,
  input wire night_raw,
  // switches
  input wire charge_sw_ff,
  input wire load_sw_ff,
  input wire [1:0] stage_ff
);
  // ****************
  // helper
  // ****************
  reg [2:0] cause_ff;
  wire bad_addr = (paddr > 12'h024) || (paddr[1:0] != 2'h0);
  // allow a short pipeline between a tick or a write and the outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) cause_ff <= 3'h0;
    else cause_ff <= {cause_ff[1:0], tick | (psel & penable & pwrite)};
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************
  // properties
  // ****************
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  property p_ready_after_setup;
    s_setup |=> s_answer;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("pready not one cycle after setup");
  property p_ready_cause;
    pready |-> $past(psel && !penable);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("pready without setup");
  property p_err_bad;
    (psel && !penable && bad_addr) |=> pslverr && pready;
  endproperty
  a_err_bad: assert property (p_err_bad) else $error("no error on unmapped access");
  property p_err_good;
    (psel && !penable && !bad_addr) |=> !pslverr;
  endproperty
  a_err_good: assert property (p_err_good) else $error("error on mapped access");
  property p_rd_hold;
    !(psel && !penable && !pwrite) |=> $stable(prdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
  property p_sw_paced;
    $changed(charge_sw_ff) |-> |cause_ff;
  endproperty
  a_sw_paced: assert property (p_sw_paced) else $error("charge switch moved off tick");
  property p_stage_paced;
    $changed(stage_ff) |-> |cause_ff;
  endproperty
  a_stage_paced: assert property (p_stage_paced) else $error("stage moved off tick");
  property p_stage_order;
    $changed(stage_ff) |-> stage_ff == $past(stage_ff) + 2'h1 || stage_ff == 2'h0 ||
      ($past(stage_ff) == 2'h0 && stage_ff == 2'h2);
  endproperty
  a_stage_order: assert property (p_stage_order) else $error("illegal stage step");
endmodule
bind csr_core csr_core_chk #(.TENTH_HOUR_TICKS(TENTH_HOUR_TICKS)) csr_core_chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tick(tick), .vbat_raw(vbat_raw), .ichg_raw(ichg_raw), .night_raw(night_raw),
  .charge_sw_ff(charge_sw_ff), .load_sw_ff(load_sw_ff), .stage_ff(stage_ff)
);
`default_nettype wire

// ---- csr_vsense.sv ----
// battery voltage sense and charge current model for the regulator
// assumes the bench sets the resting level; current flows only while switched on
`timescale 1ns/10ps
`default_nettype none
module csr_vsense (
  // clock
  input wire pclk,
  // control
  input wire [11:0] level,
  input wire charge_sw_ff,
  // sense
  output logic [11:0] vbat_raw,
  output logic [7:0] ichg_raw
);
  // current stays under the cap so the duty trim never interferes
  always @(posedge pclk) begin
    vbat_raw <= level;
    ichg_raw <= charge_sw_ff ? 8'h1e : 8'h00;
  end
endmodule
`default_nettype wire

// ---- charge_stage_regulator_presets_tb_top.sv ----
// self-checking bench for the regulator: presets, clamps, switching band, stage timers
// assumes csr_core with a two-tick tenth hour and the csr_vsense model beside it
`timescale 1ns/10ps
`default_nettype none
module charge_stage_regulator_presets_tb_top;
  // addr, field lsb, width, low, high
  localparam logic [47:0] RANGES [0:9] = '{
    48'h004_00_9_087_0a5, 48'h008_00_8_014_096, 48'h008_10_9_08c_0aa, 48'h00c_00_9_087_09b,
    48'h010_00_9_082_096, 48'h014_00_9_001_00a, 48'h014_10_9_06e_082,
    48'h018_08_5_001_014, 48'h018_10_6_001_028, 48'h018_18_4_000_008};
  // expected switch, battery level
  localparam logic [12:0] BAND [0:5] = '{13'h108c, 13'h0096, 13'h0094, 13'h1092, 13'h1095, 13'h0096};
  logic pclk, presetn, psel, penable, pwrite, tick, night_raw;
  logic pready, pslverr, charge_sw_ff, load_sw_ff, e;
  logic [11:0] paddr, level, vbat_raw;
  logic [31:0] pwdata, prdata, q;
  logic [7:0] ichg_raw;
  logic [1:0] stage_ff;
  int err_count, comparisons;
  csr_core #(.TENTH_HOUR_TICKS(16'd2)) csr_core_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tick(tick), .vbat_raw(vbat_raw), .ichg_raw(ichg_raw), .night_raw(night_raw),
    .charge_sw_ff(charge_sw_ff), .load_sw_ff(load_sw_ff), .stage_ff(stage_ff));
  csr_vsense csr_vsense_inst (
    .pclk(pclk), .level(level), .charge_sw_ff(charge_sw_ff), .vbat_raw(vbat_raw), .ichg_raw(ichg_raw));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // ****************
  // tasks
  // ****************
  task automatic complete_run;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x, input string m);
    comparisons++;
    if (s !== x) begin
      err_count++;
      $display("[FAIL] %0t %s: saw %h expected %h", $time, m, s, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) chk(32'h0, 32'h1, "apb no answer");
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic ticks(input int k);
    repeat (k) begin
      @(posedge pclk);
      tick <= 1'b1;
      @(posedge pclk);
      tick <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask
  // level settles through the input synchroniser before the tick
  task automatic volts(input logic [11:0] v, input int k);
    level <= v;
    repeat (4) @(posedge pclk);
    ticks(k);
  endtask
  function automatic logic [11:0] clampf(input logic [11:0] v, input logic [11:0] lo, input logic [11:0] hi);
    return v < lo ? lo : (v > hi ? hi : v);
  endfunction
  // run takes about a thousand cycles; the limit leaves a wide margin
  initial begin
    #400000;
    err_count++;
    complete_run;
  end
  // ****************
  // tests
  // ****************
  initial begin
    logic [47:0] r;
    logic [11:0] v, m;
    logic [9:0] t0;
    {psel, penable, pwrite, tick, night_raw, presetn} = 6'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    level = 12'h08c;
    err_count = 0;
    comparisons = 0;
    void'($urandom(32'h2d138346));
    repeat (5) @(posedge pclk);
    chk({pready, charge_sw_ff, load_sw_ff, stage_ff}, 32'h0, "reset outputs");
    presetn <= 1'b1;
    rd(12'h000);
    chk(q, 32'h0000_0100, "control reset");
    for (int p = 0; p < 4; p++) begin
      wr(12'h000, 32'h100 | p);
      wr(12'h004, 32'h0a0);
      rd(12'h004);
      chk(q & 32'h1ff, p[0] ? 32'h08e : 32'h096, "preset boost");
      rd(12'h00c);
      chk(q & 32'h1ff, 32'h08c, "preset absorption");
      rd(12'h014);
      chk(q & 32'h1ff, 32'h004, "preset gap");
      rd(12'h018);
      chk(q[21:16], 32'h28, "preset cap");
    end
    wr(12'h000, 32'h105);
    rd(12'h000);
    chk(q[2:0], 32'h3, "program above four");
    rd(12'h040);
    chk(e, 32'h1, "unmapped");
    rd(12'h006);
    chk(e, 32'h1, "unaligned");
    wr(12'h000, 32'h100);
    foreach (BAND[i]) begin
      volts(BAND[i][11:0], 1);
      chk(charge_sw_ff, BAND[i][12], "switching band");
    end
    chk(stage_ff, 32'h0, "still boost");
    volts(12'h08c, 0);
    rd(12'h024);
    t0 = q[9:0];
    ticks(10);
    rd(12'h024);
    chk(q[9:0], t0, "timer halted");
    volts(12'h094, 4);
    rd(12'h024);
    chk(q[9:0], t0 + 10'h2, "timer resumed");
    for (int j = 0; j < 60 && stage_ff === 2'h0; j++) begin
      rd(12'h024);
      t0 = q[9:0];
      ticks(1);
    end
    chk(stage_ff, 32'h2, "absorption after boost");
    chk(t0 >= 10'h013, 32'h1, "boost duration reached");
    volts(12'h06e, 2);
    chk(stage_ff, 32'h0, "return to boost");
    chk(load_sw_ff, 32'h0, "low battery disconnect");
    wr(12'h000, 32'h102);
    night_raw <= 1'b1;
    volts(12'h082, 2);
    chk(load_sw_ff, 32'h1, "night light");
    volts(12'h06e, 2);
    chk(load_sw_ff, 32'h0, "night light cut");
    wr(12'h000, 32'h104);
    foreach (RANGES[i]) begin
      r = RANGES[i];
      m = (12'h1 << r[27:24]) - 12'h1;
      for (int j = 0; j < 3; j++) begin
        v = j == 0 ? 12'h0 : (j == 1 ? m : 12'($urandom) & m);
        wr(r[47:36], 32'(v) << r[35:28]);
        rd(r[47:36]);
        chk((q >> r[35:28]) & 32'(m), 32'(clampf(v, r[23:12], r[11:0])), "clamped");
      end
    end
    wr(12'h004, 32'h090);
    wr(12'h000, 32'h10c);
    wr(12'h004, 32'h0a0);
    wr(12'h000, 32'h108);
    rd(12'h004);
    chk(q & 32'h1ff, 32'h090, "locked write");
    rd(12'h000);
    chk(q & 32'hfff, 32'h10c, "locked program");
    wr(12'h000, 32'h104);
    rd(12'h000);
    chk(q & 32'hfff, 32'h104, "unlock");
    wr(12'h000, 32'h100);
    volts(12'h0c8, 2);
    chk(charge_sw_ff, 32'h0, "12 v scaling");
    wr(12'h000, 32'h200);
    ticks(2);
    chk(charge_sw_ff, 32'h1, "24 v scaling");
    wr(12'h000, 32'h210);
    ticks(2);
    chk(charge_sw_ff, 32'h0, "inverted switch");
    wr(12'h000, 32'h100);
    repeat (30) volts(12'h064 + 12'($urandom_range(0, 120)), 1);
    complete_run;
  end
endmodule
`default_nettype wire
